// file: hdl/cmb_consts.svh
/*
  Constants of the message-buffer state logic: status codes, field
  positions, register word addresses and the copy length.
  Assumes inclusion by the package; the design file uses its macros without including it.
*/
`ifndef CMB_CONSTS_SVH
`define CMB_CONSTS_SVH

// status codes of one buffer
`define CMB_ST_RX_IDLE    4'h0
`define CMB_ST_RX_ARMED   4'h2
`define CMB_ST_RX_FULL    4'h4
`define CMB_ST_RX_OVR     4'h6
`define CMB_ST_TX_IDLE    4'h8
`define CMB_ST_TX_AWAIT   4'hA
`define CMB_ST_TX_ONCE    4'hC
`define CMB_ST_TX_SENDAW  4'hE
`define CMB_BUSY_BIT      0
`define CMB_TX_BIT        3

// register word addresses
`define CMB_A_STAT        6'h00
`define CMB_A_CFG         6'h0F
`define CMB_A_PAY         6'h10
`define CMB_CFG_LOCK_BIT  0

// timing and buffer count
`define CMB_COPY_CYCLES   5'h11
`define CMB_NBUF          15

`endif

// file: hdl/cmb_pkg.sv
/*
  Types of the message-buffer state logic.
  Assumes cmb_consts.svh is on the include path.
*/
package cmb_pkg;
  `include "cmb_consts.svh"

  typedef struct packed {
    logic [10:0] id;
    logic        rtr;
    logic [3:0]  dlc;
    logic [15:0] data;
  } cmb_frame_s;

  typedef enum logic {CMB_COPY_IDLE, CMB_COPY_RUN} cmb_copy_e;
endpackage

// file: hdl/cmb_msg_buffers.sv
/*
  Message-buffer state logic of a CAN controller: receive copy from the
  staging buffer into fifteen message buffers, status code handling and
  transmit scheduling with pre-emption and retry.
  Assumes a protocol engine that drives the frame events below as
  one-cycle pulses synchronous to clk, and a CPU on the register port.
*/
// Summary of operation
// RULE_01: reception starts on dominant level; matching frames go to staging buffer.
// RULE_02: staging contents move to a buffer only after the sixth EOF bit.
// RULE_03: one copy lasts at least seventeen clock cycles, any frame length.
// RULE_04: busy bit set during copy, cleared right after data is written.
// RULE_05: copy into armed buffer gives full; receive-idle stays unchanged.
// RULE_06: another frame into a full buffer gives overrun.
// RULE_07: during copy only status writes count; table update still applied.
// RULE_08: codes idle 0000b, armed 0010b, full 0100b, full copying 0101b.
// RULE_09: software programs mask, then identifier, then armed code.
// RULE_10: armed buffer entering full raises its interrupt request.
// RULE_11: interrupt routine re-arms, reads, rechecks until busy clears.
// RULE_12: with lock-after-receive the buffer holds its first valid frame.
// RULE_13: status bit 3 set means transmit buffer; transmit-idle accepts writes.
// RULE_14: single-transmit code starts sending; busy while sending, idle after.
// RULE_15: failed transmission stays busy and is retried until success or cancel.
// RULE_16: sent remote request switches the buffer to armed receive.
// RULE_17: await-remote buffer hit by remote frame sends, then awaits again.
// RULE_18: send-then-await code transmits, then enters await-remote.
// RULE_19: transmit-busy buffer takes only status bits 3 to 1; busy bit never.
// RULE_20: from CRC start the best pending buffer is scheduled and marked busy.
// RULE_21: scheduled buffer may be cancelled; a displaced one returns to pending.
// RULE_22: lost arbitration or error halts sending; reselect and send again.
// RULE_23: rank is priority nibble over buffer number; lowest wins.
// RULE_24: fifteen buffers, each receive or transmit.
`timescale 1ns/10ps
module cmb_msg_buffers
  import cmb_pkg::*;
#(
  parameter int NBUF = `CMB_NBUF // see RULE_24
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // register port
  input  wire logic [5:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  // receive side of the protocol engine
  input  wire logic        rx_sof,
  input  wire logic        rx_abort,
  input  wire logic        rx_done,
  input  cmb_frame_s       rx_frame,
  input  wire logic [14:0] rx_hit,
  output logic             rx_active,
  output logic [14:0]      rx_full_evt,
  // transmit side of the protocol engine
  input  wire logic        crc_start,
  input  wire logic        tx_start,
  input  wire logic        tx_ok,
  input  wire logic        tx_fail,
  output logic             tx_req,
  output logic [3:0]       tx_buf,
  output cmb_frame_s       tx_frame,
  output logic [14:0]      tx_done_evt
);

  logic [3:0]  st_q   [NBUF];
  logic [3:0]  pri_q  [NBUF];
  cmb_frame_s  mem_q  [NBUF];
  cmb_frame_s  stage_q;
  cmb_copy_e   copy_q;
  logic [4:0]  cnt_q;
  logic [3:0]  tgt_q;
  logic        lock_q;
  logic        sched_v_q;
  logic [3:0]  sched_q;
  logic        cur_v_q;
  logic [3:0]  cur_q;
  logic        in_crc_q;

  logic [NBUF-1:0] wr_st;
  logic [NBUF-1:0] wr_pay;
  logic [NBUF-1:0] rx_ok;
  logic [NBUF-1:0] pend;
  logic [NBUF-1:0] set_busy;
  logic [NBUF-1:0] drop_busy;
  logic            copy_start;
  logic            copy_end;
  logic [3:0]      first_rx;
  logic            first_v;
  logic [3:0]      best;
  logic            best_v;
  logic [7:0]      best_key;
  logic [7:0]      sched_key;
  logic            cancel;
  logic            take;
  logic            win_open;

  // rx_active tracks a frame on the bus
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_active <= 1'b0;
    end else if (rx_sof) begin
      rx_active <= 1'b1; // see RULE_01
    end else if (rx_done || rx_abort) begin
      rx_active <= 1'b0;
    end
  end

  // first receivable buffer in ascending order
  always_comb begin
    first_v  = 1'b0;
    first_rx = 4'h0;
    for (int i = NBUF - 1; i >= 0; i--) begin
      if (rx_ok[i]) begin
        first_v  = 1'b1;
        first_rx = 4'(i);
      end
    end
  end

  // best pending transmit buffer
  always_comb begin
    best_v   = 1'b0;
    best     = 4'h0;
    best_key = 8'hFF;
    for (int i = 0; i < NBUF; i++) begin
      if (pend[i] && (!best_v || {pri_q[i], 4'(i)} < best_key)) begin // see RULE_23
        best_v   = 1'b1;
        best     = 4'(i);
        best_key = {pri_q[i], 4'(i)};
      end
    end
  end

  assign sched_key  = {pri_q[sched_q], sched_q};
  assign copy_start = (copy_q == CMB_COPY_IDLE) && rx_done && first_v; // see RULE_02
  assign copy_end   = (copy_q == CMB_COPY_RUN) && (cnt_q == `CMB_COPY_CYCLES - 5'h01);
  assign cancel     = sched_v_q && wr_st[sched_q] && (wdata[3:2] != 2'b11); // see RULE_21
  assign win_open   = !cur_v_q || in_crc_q; // see RULE_20
  assign take       = win_open && best_v && !tx_start && !tx_fail && !cancel
                      && (!sched_v_q || best_key < sched_key);

  // staging buffer and copy sequencer
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      copy_q  <= CMB_COPY_IDLE;
      cnt_q   <= 5'h00;
      tgt_q   <= 4'h0;
      stage_q <= '0;
    end else begin
      case (copy_q)
        CMB_COPY_IDLE: begin
          cnt_q <= 5'h00;
          if (copy_start) begin
            stage_q <= rx_frame; // see RULE_01
            tgt_q   <= first_rx;
            copy_q  <= CMB_COPY_RUN;
          end
        end
        CMB_COPY_RUN: begin
          cnt_q <= cnt_q + 5'h01; // see RULE_03
          if (copy_end) begin
            copy_q <= CMB_COPY_IDLE;
          end
        end
        default: copy_q <= CMB_COPY_IDLE;
      endcase
    end
  end

  // scheduler: scheduled and in-flight buffer
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sched_v_q <= 1'b0;
      sched_q   <= 4'h0;
      cur_v_q   <= 1'b0;
      cur_q     <= 4'h0;
      in_crc_q  <= 1'b0;
    end else begin
      if (crc_start && cur_v_q) begin
        in_crc_q <= 1'b1;
      end
      if (tx_ok) begin
        cur_v_q <= 1'b0;
      end
      if (tx_fail) begin // see RULE_22
        cur_v_q  <= 1'b0;
        in_crc_q <= 1'b0;
        if (cur_v_q && st_q[cur_q][`CMB_BUSY_BIT]) begin
          sched_v_q <= 1'b1; // see RULE_15
          sched_q   <= cur_q;
        end
      end else if (tx_start && sched_v_q) begin
        cur_v_q   <= 1'b1;
        cur_q     <= sched_q;
        sched_v_q <= 1'b0;
        in_crc_q  <= 1'b0;
      end else if (cancel) begin
        sched_v_q <= 1'b0;
      end else if (take) begin
        sched_v_q <= 1'b1;
        sched_q   <= best;
      end
    end
  end

  // per-buffer controls and status codes
  for (genvar i = 0; i < NBUF; i++) begin : g_buf
    logic       copying;
    logic       txbusy;
    logic [2:0] code_in;
    logic [2:0] code_up;
    logic       is_cur;

    assign copying  = (copy_q == CMB_COPY_RUN) && (tgt_q == 4'(i));
    assign txbusy   = st_q[i][`CMB_TX_BIT] && st_q[i][`CMB_BUSY_BIT];
    assign is_cur   = cur_v_q && (cur_q == 4'(i));
    assign wr_st[i] = wr && (addr == `CMB_A_STAT + 6'(i));
    assign wr_pay[i] = wr && (addr == `CMB_A_PAY + 6'(i)) && !copying && !txbusy;
    assign rx_ok[i] = rx_hit[i] && !st_q[i][`CMB_TX_BIT]
                      && (st_q[i] == `CMB_ST_RX_ARMED
                          || (!lock_q && st_q[i][3:1] == 3'b010)
                          || (!lock_q && st_q[i][3:1] == 3'b011)); // see RULE_12
    assign pend[i]  = (st_q[i] == `CMB_ST_TX_ONCE || st_q[i] == `CMB_ST_TX_SENDAW)
                      && !(sched_v_q && sched_q == 4'(i));
    assign set_busy[i]  = take && (best == 4'(i));
    assign drop_busy[i] = (take && sched_v_q && sched_q == 4'(i))
                          || (tx_fail && sched_v_q && sched_q == 4'(i)
                              && !(cur_v_q && cur_q == 4'(i)));
    assign code_in  = wr_st[i] ? wdata[3:1] : st_q[i][3:1];
    // full/overrun update applied at the end of a copy
    always_comb begin
      case (code_in)
        3'b001:  code_up = 3'b010; // see RULE_05
        3'b010:  code_up = 3'b011; // see RULE_06
        default: code_up = code_in;
      endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        st_q[i]  <= `CMB_ST_RX_IDLE;
        pri_q[i] <= 4'h0;
      end else begin
        if (wr_st[i]) begin
          if (txbusy) begin
            st_q[i] <= {wdata[3:1], wdata[3:2] == 2'b11}; // see RULE_19
          end else if (copying) begin
            st_q[i][3:1] <= wdata[3:1]; // see RULE_07
          end else begin
            st_q[i]  <= {wdata[3:1], 1'b0}; // see RULE_13
            pri_q[i] <= wdata[7:4];
          end
        end
        if (copy_start && first_rx == 4'(i)) begin
          st_q[i][`CMB_BUSY_BIT] <= 1'b1; // see RULE_04
        end
        if (copy_end && copying) begin
          st_q[i] <= {code_up, 1'b0}; // see RULE_04
        end
        if (set_busy[i]) begin
          st_q[i][`CMB_BUSY_BIT] <= 1'b1; // see RULE_20
        end
        if (drop_busy[i]) begin
          st_q[i][`CMB_BUSY_BIT] <= 1'b0; // see RULE_21
        end
        if (tx_ok && is_cur && st_q[i] == (`CMB_ST_TX_ONCE | 4'h1)) begin
          st_q[i] <= mem_q[i].rtr ? `CMB_ST_RX_ARMED : `CMB_ST_TX_IDLE; // see RULE_16
        end
        if (tx_ok && is_cur && st_q[i] == (`CMB_ST_TX_SENDAW | 4'h1)) begin
          st_q[i] <= `CMB_ST_TX_AWAIT; // see RULE_18
        end
        if (rx_done && rx_frame.rtr && rx_hit[i] && st_q[i] == `CMB_ST_TX_AWAIT) begin
          st_q[i] <= `CMB_ST_TX_SENDAW; // see RULE_17
        end
      end
    end

    // identifier and data words
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        mem_q[i] <= '0;
      end else if (copy_end && copying) begin
        mem_q[i] <= stage_q;
      end else if (wr_pay[i]) begin
        mem_q[i] <= wdata;
      end
    end

    // event pulses for the interrupt unit
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        rx_full_evt[i] <= 1'b0;
        tx_done_evt[i] <= 1'b0;
      end else begin
        rx_full_evt[i] <= copy_end && copying && code_in == 3'b001; // see RULE_10
        tx_done_evt[i] <= tx_ok && is_cur && txbusy; // see RULE_14
      end
    end
  end

  // configuration
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lock_q <= 1'b0;
    end else if (wr && addr == `CMB_A_CFG) begin
      lock_q <= wdata[`CMB_CFG_LOCK_BIT];
    end
  end

  // read data, valid one cycle after rd
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= 32'h0000_0000;
    end else if (rd) begin
      rdata <= 32'h0000_0000;
      if (addr < `CMB_A_STAT + 6'(NBUF)) begin
        rdata <= {24'h00_0000, pri_q[addr[3:0]], st_q[addr[3:0]]}; // see RULE_08
      end else if (addr == `CMB_A_CFG) begin
        rdata <= {31'h0000_0000, lock_q};
      end else if (addr >= `CMB_A_PAY && addr < `CMB_A_PAY + 6'(NBUF)) begin
        if (!(st_q[addr[3:0]][`CMB_TX_BIT] && st_q[addr[3:0]][`CMB_BUSY_BIT])) begin
          rdata <= mem_q[addr[3:0]];
        end
      end
    end
  end

  // transmit request towards the protocol engine
  assign tx_req = sched_v_q; // see RULE_14
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_buf   <= 4'h0;
      tx_frame <= '0;
    end else begin
      tx_buf   <= sched_q;
      tx_frame <= mem_q[sched_q];
    end
  end

endmodule

// file: tb/cmb_msg_buffers_monitor.sv
/*
  Port checker for cmb_msg_buffers.
  Assumes binding to the design top, one clock domain.
*/
`timescale 1ns/10ps
module cmb_msg_buffers_monitor
  import cmb_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        arst_n,
  // watched ports
  input wire logic        rx_sof,
  input wire logic        rx_abort,
  input wire logic        rx_done,
  input wire logic        rx_active,
  input wire logic [14:0] rx_full_evt,
  input wire logic        tx_start,
  input wire logic        tx_ok,
  input wire logic        tx_fail,
  input wire logic        tx_req,
  input wire logic [3:0]  tx_buf,
  input cmb_frame_s       tx_frame,
  input wire logic [14:0] tx_done_evt
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  chk_rx_act_set: assert property (rx_sof |=> rx_active)
    else $error("rx_active not set after start");
  chk_rx_act_clr: assert property (rx_done |=> !rx_active)
    else $error("rx_active not cleared after done");
  chk_rx_act_abort: assert property (rx_abort |=> !rx_active)
    else $error("rx_active not cleared after abort");
  chk_copy_len: assert property (|rx_full_evt |-> $past(rx_done, 18))
    else $error("full event not 18 cycles after done");
  chk_full_one: assert property (|rx_full_evt |-> $onehot(rx_full_evt))
    else $error("full event hits several buffers");
  chk_done_ok: assert property (|tx_done_evt |-> $past(tx_ok))
    else $error("done event without tx_ok");
  chk_req_drop: assert property (tx_start |=> !tx_req)
    else $error("tx_req held after start");
  chk_fail_retry: assert property (tx_fail |-> ##[1:3] tx_req)
    else $error("no reschedule after failure");
  chk_buf_range: assert property (tx_req |-> tx_buf < 4'hF)
    else $error("tx_buf out of range");
  chk_frame_lock: assert property (tx_req && $past(tx_req) && $stable(tx_buf)
    |-> $stable(tx_frame))
    else $error("busy buffer contents changed");
  cov_full: cover property (|rx_full_evt);
  cov_done: cover property (|tx_done_evt);
  cov_fail: cover property (tx_fail);
endmodule

bind cmb_msg_buffers cmb_msg_buffers_monitor u_mon (.clk, .arst_n, .rx_sof, .rx_abort, .rx_done,
  .rx_active, .rx_full_evt, .tx_start, .tx_ok, .tx_fail, .tx_req, .tx_buf, .tx_frame,
  .tx_done_evt);

// file: tb/cmb_bus_node.sv
/*
  Behavioural model of the bus and its other nodes at the engine side.
  Assumes slow and fail_now come from the testbench.
*/
`timescale 1ns/10ps
module cmb_bus_node (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // test control
  input wire logic slow,
  input wire logic fail_now,
  // engine events
  input wire logic tx_req,
  output logic     tx_start,
  output logic     crc_start,
  output logic     tx_ok,
  output logic     tx_fail
);
  logic [4:0] cnt_q;
  logic [4:0] gap;
  assign gap = slow ? 5'h08 : 5'h02;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 5'h00;
      {tx_start, crc_start, tx_ok, tx_fail} <= 4'h0;
    end else begin
      {tx_start, crc_start, tx_ok, tx_fail} <= 4'h0;
      if (cnt_q == 5'h00) begin
        if (tx_req) cnt_q <= 5'h01;
      end else if (cnt_q == gap) begin
        tx_start <= tx_req;
        cnt_q    <= tx_req ? cnt_q + 5'h01 : 5'h00;
      end else if (cnt_q == gap + 5'h06) begin
        crc_start <= !fail_now;
        tx_fail   <= fail_now;
        cnt_q     <= fail_now ? 5'h00 : cnt_q + 5'h01;
      end else if (cnt_q == gap + 5'h09) begin
        tx_ok <= 1'b1;
        cnt_q <= 5'h00;
      end else begin
        cnt_q <= cnt_q + 5'h01;
      end
    end
  end
endmodule

// file: tb/cmb_msg_buffers_tb.sv
/*
  Self-checking testbench of cmb_msg_buffers.
  Assumes the checker bind and the bus node model are compiled.
*/
`timescale 1ns/10ps
module cmb_msg_buffers_tb
  import cmb_pkg::*;
;
  logic clk, arst_n, wr, rd, rx_sof, rx_abort, rx_done, crc_start, tx_start, tx_ok;
  logic tx_fail, rx_active, tx_req, slow, fail_now, rd_p, fail_seen;
  logic [5:0] addr;
  logic [31:0] wdata, rdata, s;
  logic [14:0] rx_hit, rx_full_evt, tx_done_evt;
  logic [3:0] tx_buf;
  cmb_frame_s rx_frame, tx_frame, f, lf;
  logic [35:0] rd_q[$], rx_q[$], sel_q[$], done_q[$];
  int num_errors, comparisons;
  cmb_msg_buffers DUT (.*);
  cmb_bus_node u_node (.*);
  always #12.5 clk = ~clk;
  function automatic cmb_frame_s rnd();
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return {s[31:21], 1'b0, s[19:0]};
  endfunction
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cmp(ref logic [35:0] q[$], input logic [35:0] got);
    comparisons++;
    if (q.size() == 0 || got !== q[0]) begin
      num_errors++;
      $display("MISMATCH %0t got %h", $time, got);
    end
    if (q.size() > 0) void'(q.pop_front());
  endtask
  task automatic cmp_rd(input logic [35:0] got);
    cmp(rd_q, got);
  endtask
  task automatic cmp_full(input logic [35:0] got);
    cmp(rx_q, got);
  endtask
  task automatic cmp_sel(input logic [35:0] got);
    cmp(sel_q, got);
  endtask
  task automatic cmp_done(input logic [35:0] got);
    cmp(done_q, got);
  endtask
  always @(posedge clk) begin
    if (rd_p) cmp_rd({4'h0, rdata});
    rd_p = rd;
    if (|rx_full_evt) cmp_full({21'h0, rx_full_evt});
    if (tx_start) cmp_sel({tx_buf, tx_frame});
    if (|tx_done_evt) cmp_done({21'h0, tx_done_evt});
    if (tx_fail) fail_seen = 1'b1;
  end
  task automatic wreg(input logic [5:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rreg(input logic [5:0] a, input logic [31:0] e);
    rd_q.push_back({4'h0, e});
    addr <= a;
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
  endtask
  task automatic nop(input int n);
    wr <= 1'b0;
    rd <= 1'b0;
    repeat (n) @(posedge clk);
  endtask
  task automatic rxf(input logic [14:0] h, input cmb_frame_s fr);
    nop(0);
    rx_sof <= 1'b1;
    @(posedge clk);
    rx_sof <= 1'b0;
    rx_done <= 1'b1;
    rx_frame <= fr;
    rx_hit <= h;
    @(posedge clk);
    rx_done <= 1'b0;
  endtask
  task automatic waitq();
    nop(1);
    for (int i = 0; i < 3000; i++) begin
      if (sel_q.size() + done_q.size() + rx_q.size() == 0) return;
      @(posedge clk);
    end
    num_errors++;
    $display("MISMATCH %0t wait limit", $time);
    end_of_test();
  endtask
  task automatic txr(input logic [3:0] b, input logic [7:0] c, input logic r,
                     input logic [3:0] a);
    wreg(b, 8'h08);
    lf = rnd();
    lf.rtr = r;
    wreg(6'h10 + b, lf);
    sel_q.push_back({b, lf});
    done_q.push_back(36'h1 << b);
    wreg(b, c);
    waitq();
    rreg(b, a);
  endtask
  initial begin
    {clk, arst_n, wr, rd, rx_sof, rx_abort, rx_done, slow, fail_now, rd_p} = 0;
    {addr, wdata, rx_hit, rx_frame, fail_seen} = 0;
    s = 32'h415e;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 15; i++) rreg(i, 0);
    rreg(6'h3F, 0);
    nop(0);
    rx_sof <= 1'b1;
    @(posedge clk);
    rx_sof <= 1'b0;
    rx_abort <= 1'b1;
    @(posedge clk);
    rx_abort <= 1'b0;
    $display("test reset done");
    f = rnd();
    wreg(6'h03, 2);
    wreg(6'h05, 2);
    rx_q.push_back(36'h8);
    rxf(15'h0029, f);
    rreg(6'h03, 3);
    wreg(6'h13, ~f);
    nop(20);
    rreg(6'h03, 4);
    rreg(6'h13, f);
    rreg(6'h00, 0);
    f = rnd();
    rxf(15'h0008, f);
    rreg(6'h03, 5);
    nop(20);
    rreg(6'h03, 6);
    rreg(6'h13, f);
    rx_q.push_back(36'h8);
    rxf(15'h0008, f);
    wreg(6'h03, 2);
    nop(20);
    rreg(6'h03, 4);
    wreg(6'h0F, 1);
    rx_q.push_back(36'h20);
    rxf(15'h0028, f);
    nop(20);
    rreg(6'h05, 4);
    waitq();
    $display("test receive done");
    slow <= 1'b1;
    foreach (sel_q[i]) ;
    for (int k = 0; k < 3; k++) begin
      wreg(6'h02 + 2 * k, 8'h08);
      lf = rnd();
      wreg(6'h12 + 2 * k, lf);
      sel_q.push_back({4'h2 + 4'h2 * k, lf});
    end
    sel_q = {sel_q[1], sel_q[2], sel_q[0]};
    done_q = {36'h10, 36'h40, 36'h4};
    wreg(6'h02, 8'h3C);
    wreg(6'h06, 8'h1C);
    wreg(6'h04, 8'h1C);
    waitq();
    rreg(6'h02, 8'h38);
    rreg(6'h04, 8'h18);
    $display("test priority done");
    fail_now <= 1'b1;
    fail_seen = 1'b0;
    txr(4'h7, 8'h0C, 1'b0, 8'h08);
    rreg(6'h17, lf);
    $display("test retry done");
    slow <= 1'b0;
    txr(4'h8, 8'h0C, 1'b1, 8'h02);
    txr(4'h9, 8'h0E, 1'b0, 8'h0A);
    f = rnd();
    f.rtr = 1'b1;
    sel_q.push_back({4'h9, lf});
    done_q.push_back(36'h200);
    rxf(15'h0200, f);
    waitq();
    rreg(6'h09, 8'h0A);
    slow <= 1'b1;
    wreg(6'h0A, 8'h08);
    wreg(6'h0A, 8'h0C);
    nop(3);
    wreg(6'h0A, 8'h08);
    nop(30);
    rreg(6'h0A, 8'h08);
    nop(3);
    $display("test remote and cancel done");
    end_of_test();
  end
  initial begin
    for (int i = 0; i < 50000 && fail_seen !== 1'b1; i++) begin
      @(posedge clk);
    end
    if (fail_seen === 1'b1) begin
      sel_q.push_front({4'h7, lf});
      fail_now <= 1'b0;
      rreg(6'h07, 8'h0D);
      wreg(6'h17, 0);
      rreg(6'h17, 0);
      nop(0);
    end
  end
endmodule
